// ### verilog/sdg_pkg.sv
// Constants and carrier types for the three-channel step and direction generator.
// Assumes register ports address one 32-bit register per index.
package sdg_pkg;
  // ==========================================================================
  // Register indices
  localparam logic [5:0] IDX_RATE0   = 6'h12;
  localparam logic [5:0] IDX_COUNT0  = 6'h15;
  localparam logic [5:0] IDX_TARGET0 = 6'h18;
  localparam logic [5:0] IDX_CONFIG  = 6'h23;
  // ==========================================================================
  // Configuration field layout, one group of bits per channel
  localparam int CFG_BITS_PER_CH = 4;
  localparam int CFG_ENABLE      = 0;
  localparam int CFG_CONTINUOUS  = 1;
  localparam int CFG_STEP_POL    = 2;
  localparam int CFG_DIR_POL     = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              we;
    logic              re;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] wdata;
  } sdg_req_t;
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } sdg_rsp_t;
endpackage : sdg_pkg

// ### verilog/sdg_step_dir_gen.sv
// Step and direction generator with two register ports (network side, process data side).
// Assumes both ports run on clk_sys_i; requests are single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module sdg_step_dir_gen #(
  parameter int NUM_CH = 3
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  input  wire sdg_pkg::sdg_req_t net_req_i,
  output var  sdg_pkg::sdg_rsp_t net_rsp_o,
  input  wire sdg_pkg::sdg_req_t pdi_req_i,
  output var  sdg_pkg::sdg_rsp_t pdi_rsp_o,
  output logic [NUM_CH-1:0]      pulse_out_o,
  output logic [NUM_CH-1:0]      pulse_out_inv_o,
  output logic [NUM_CH-1:0]      dir_out_o,
  output logic [NUM_CH-1:0]      dir_out_inv_o
);
  localparam int CFG_W = NUM_CH * sdg_pkg::CFG_BITS_PER_CH;

  // ==========================================================================
  // Elaboration check
  // The fixed index spacing only holds three channels; the configuration word holds up to eight.
  if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_ch
    $error("sdg_step_dir_gen supports one to three channels");
  end

  // All configuration groups must fit in one data word.
  if (CFG_W > sdg_pkg::DATA_W) begin : g_bad_cfg
    $error("sdg_step_dir_gen configuration does not fit one word");
  end

  // Rate, count and target blocks must not overlap one another.
  if (sdg_pkg::IDX_RATE0 + NUM_CH > sdg_pkg::IDX_COUNT0 ||
      sdg_pkg::IDX_COUNT0 + NUM_CH > sdg_pkg::IDX_TARGET0) begin : g_bad_map
    $error("sdg_step_dir_gen register blocks overlap");
  end

  // ==========================================================================
  // Configuration register
  logic [CFG_W-1:0] cfg_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= '0;
    end else if (ce_i) begin
      // The network side wins when both ports write the same cycle.
      if (net_req_i.we && net_req_i.idx == sdg_pkg::IDX_CONFIG) begin
        cfg_q <= net_req_i.wdata[CFG_W-1:0];
      end else if (pdi_req_i.we && pdi_req_i.idx == sdg_pkg::IDX_CONFIG) begin
        cfg_q <= pdi_req_i.wdata[CFG_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Channels
  logic [31:0] rate_q   [NUM_CH];
  logic [31:0] count_q  [NUM_CH];
  logic [31:0] target_q [NUM_CH];

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    localparam logic [5:0] RATE_IDX   = 6'(sdg_pkg::IDX_RATE0 + g);
    localparam logic [5:0] TARGET_IDX = 6'(sdg_pkg::IDX_TARGET0 + g);
    localparam int CB = g * sdg_pkg::CFG_BITS_PER_CH;

    logic        net_rate_wr;
    logic        pdi_rate_wr;
    logic        net_tgt_wr;
    logic        pdi_tgt_wr;
    logic        enable;
    logic        continuous;
    logic        step_pol;
    logic        dir_pol;
    logic        negative;
    logic [31:0] magnitude;
    logic [32:0] acc_sum;
    logic [31:0] acc_q;
    logic        step_fire;

    assign net_rate_wr = net_req_i.we && net_req_i.idx == RATE_IDX;
    assign pdi_rate_wr = pdi_req_i.we && pdi_req_i.idx == RATE_IDX;
    assign net_tgt_wr  = net_req_i.we && net_req_i.idx == TARGET_IDX;
    assign pdi_tgt_wr  = pdi_req_i.we && pdi_req_i.idx == TARGET_IDX;
    assign enable      = cfg_q[CB + sdg_pkg::CFG_ENABLE];
    assign continuous  = cfg_q[CB + sdg_pkg::CFG_CONTINUOUS];
    assign step_pol    = cfg_q[CB + sdg_pkg::CFG_STEP_POL];
    assign dir_pol     = cfg_q[CB + sdg_pkg::CFG_DIR_POL];
    assign negative    = rate_q[g][31];
    // The most negative rate keeps a magnitude of two to the 31st.
    always_comb begin
      if (negative) begin
        magnitude = 32'(-rate_q[g]);
      end else begin
        magnitude = rate_q[g];
      end
    end

    assign acc_sum     = {1'b0, acc_q} + {1'b0, magnitude};
    // Stepping needs an enabled channel and pulses left, unless continuous.
    assign step_fire   = enable && acc_sum[32]
                         && (continuous || target_q[g] != 32'h0000_0000);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        rate_q[g] <= sdg_pkg::RESET_WORD;
      end else if (ce_i) begin
        if (net_rate_wr) begin
          rate_q[g] <= net_req_i.wdata;
        end else if (pdi_rate_wr) begin
          rate_q[g] <= pdi_req_i.wdata;
        end
      end
    end

    // A disabled channel holds its phase at zero so it restarts cleanly.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        acc_q <= 32'h0000_0000;
      end else if (ce_i) begin
        acc_q <= enable ? acc_sum[31:0] : 32'h0000_0000;
      end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        count_q[g] <= sdg_pkg::RESET_WORD;
      end else if (ce_i && step_fire) begin
        count_q[g] <= negative ? count_q[g] - 32'h0000_0001
                               : count_q[g] + 32'h0000_0001;
      end
    end

    // A write in the same cycle as a pulse replaces the target outright.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        target_q[g] <= sdg_pkg::RESET_WORD;
      end else if (ce_i) begin
        if (net_tgt_wr) begin
          target_q[g] <= net_req_i.wdata;
        end else if (pdi_tgt_wr) begin
          target_q[g] <= pdi_req_i.wdata;
        end else if (step_fire && !continuous) begin
          target_q[g] <= target_q[g] - 32'h0000_0001;
        end
      end
    end

    // Step pair; both pins come from flip-flops so they never glitch apart.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pulse_out_o[g]     <= 1'b0;
        pulse_out_inv_o[g] <= 1'b1;
      end else if (ce_i) begin
        pulse_out_o[g]     <= step_fire ^ step_pol;
        pulse_out_inv_o[g] <= ~(step_fire ^ step_pol);
      end
    end

    // Direction pair follows the sign even while the channel is disabled.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        dir_out_o[g]     <= 1'b0;
        dir_out_inv_o[g] <= 1'b1;
      end else if (ce_i) begin
        dir_out_o[g]     <= negative ^ dir_pol;
        dir_out_inv_o[g] <= ~(negative ^ dir_pol);
      end
    end
  end

  // ==========================================================================
  // Read paths
  // Write-only registers and unmapped indices read as zero.
  function automatic logic [31:0] read_word(input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int c = 0; c < NUM_CH; c++) begin
      if (idx == 6'(sdg_pkg::IDX_COUNT0 + c)) begin
        v = count_q[c];
      end
      if (idx == 6'(sdg_pkg::IDX_TARGET0 + c)) begin
        v = target_q[c];
      end
    end
    return v;
  endfunction : read_word

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      net_rsp_o <= '0;
    end else if (ce_i) begin
      net_rsp_o.valid <= net_req_i.re;
      net_rsp_o.data  <= net_req_i.re ? read_word(net_req_i.idx) : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pdi_rsp_o <= '0;
    end else if (ce_i) begin
      pdi_rsp_o.valid <= pdi_req_i.re;
      pdi_rsp_o.data  <= pdi_req_i.re ? read_word(pdi_req_i.idx) : 32'h0000_0000;
    end
  end
endmodule : sdg_step_dir_gen
`default_nettype wire

// ### bench/sdg_checker.sv
// Port assertions for the step and direction generator.
// Assumes it is bound to sdg_step_dir_gen and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sdg_checker #(parameter int NUM_CH = 3) (
  input wire logic [0:0]        clk_sys_i,
  input wire logic [0:0]        rstn_i,
  input wire logic [0:0]        ce_i,
  input wire sdg_pkg::sdg_req_t net_req_i,
  input wire sdg_pkg::sdg_rsp_t net_rsp_o,
  input wire sdg_pkg::sdg_req_t pdi_req_i,
  input wire sdg_pkg::sdg_rsp_t pdi_rsp_o,
  input wire logic [NUM_CH-1:0] pulse_out_o,
  input wire logic [NUM_CH-1:0] pulse_out_inv_o,
  input wire logic [NUM_CH-1:0] dir_out_o,
  input wire logic [NUM_CH-1:0] dir_out_inv_o
);
  // ==========================================================================
  // Port relations
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  wire logic any_we = ce_i && (net_req_i.we || pdi_req_i.we);
  step_pair_a: assert property (pulse_out_inv_o == ~pulse_out_o) else $error("step");
  dir_pair_a: assert property (dir_out_inv_o == ~dir_out_o) else $error("dir");
  net_read_a: assert property (ce_i && net_req_i.re |=> net_rsp_o.valid) else $error("net");
  pdi_read_a: assert property (ce_i && pdi_req_i.re |=> pdi_rsp_o.valid) else $error("pdi");
  net_cause_a: assert property (net_rsp_o.valid |-> $past(ce_i && net_req_i.re))
    else $error("cause");
  rsp_idle_a: assert property (!pdi_rsp_o.valid |-> pdi_rsp_o.data == '0) else $error("idle");
  freeze_out_a: assert property (!ce_i |=> $stable(pulse_out_o) && $stable(dir_out_o))
    else $error("freeze");
  dir_cause_a: assert property ($changed(dir_out_o) |-> $past(any_we) || $past(any_we, 2))
    else $error("dir cause");
endmodule : sdg_checker
`default_nettype wire

// ### bench/sdg_motor_model.sv
// Driver stage model: turns step edges into a signed position per channel.
// Assumes step and direction polarity bits are clear while compared.
`timescale 1ns/1ps
`default_nettype none
module sdg_motor_model (
  input wire logic [0:0]  clk_sys_i,
  input wire logic [0:0]  rstn_i,
  input wire logic [2:0]  step_i,
  input wire logic [2:0]  step_inv_i,
  input wire logic [2:0]  dir_i,
  output logic [2:0][31:0] pos_o
);
  // ==========================================================================
  // Position
  // Edges are counted, so a pulse held by a low clock enable counts once.
  logic [2:0] prev_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 3'h0;
      pos_o  <= '0;
    end else begin
      prev_q <= step_i;
      for (int i = 0; i < 3; i++) begin
        if (step_i[i] && !prev_q[i] && !step_inv_i[i]) begin
          pos_o[i] <= pos_o[i] + (dir_i[i] ? 32'hffff_ffff : 32'h0000_0001);
        end
      end
    end
  end
endmodule : sdg_motor_model
`default_nettype wire

// ### bench/sdg_step_dir_gen_tb_top.sv
// Bench top: drives both register ports, checks reads and pins.
// Assumes package, checker and driver model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sdg_step_dir_gen_tb_top;
  // ==========================================================================
  // Stimulus and checks
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1;
  sdg_pkg::sdg_req_t req [2] = '{default: '0};
  sdg_pkg::sdg_rsp_t rsp [2];
  logic [2:0] pulse, pulse_n, dir, dir_n;
  logic [2:0][31:0] pos;
  logic [31:0] eq [2][$];
  logic [31:0] m;
  int err_total = 0, n_tests = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  sdg_step_dir_gen DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .net_req_i(req[0]), .net_rsp_o(rsp[0]), .pdi_req_i(req[1]), .pdi_rsp_o(rsp[1]),
    .pulse_out_o(pulse), .pulse_out_inv_o(pulse_n), .dir_out_o(dir), .dir_out_inv_o(dir_n));
  sdg_motor_model u_mot (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .step_i(pulse),
    .step_inv_i(pulse_n), .dir_i(dir), .pos_o(pos));
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic cmp_rsp(input int p);
    cmp_pin(rsp[p].data, eq[p].pop_front());
  endtask : cmp_rsp
  always @(negedge clk_sys_i) for (int p = 0; p < 2; p++) if (rsp[p].valid === 1'b1) cmp_rsp(p);
  task automatic acc(input int p, input logic w, input logic [5:0] i, input logic [31:0] d);
    req[p] = '{w, !w, i, d};
    if (!w) eq[p].push_back(d);
    tick(1);
    req[p] = '0;
    tick(1);
  endtask : acc
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    err_total++;
    final_report;
  end
  initial begin
    void'($urandom(32'he333b886));
    m = 32'h4000_0000 | ($urandom() & 32'h3fff_ffff);
    tick(20);
    rstn_i = 1'b1;
    acc(0, 0, sdg_pkg::IDX_RATE0, 0);
    acc(1, 0, sdg_pkg::IDX_TARGET0, 0);
    acc(1, 0, 6'h3f, 0);
    cmp_pin({pulse, pulse_n, dir, dir_n}, 32'h1c7);
    acc(0, 1, sdg_pkg::IDX_RATE0, 32'h4000_0000);
    acc(1, 1, sdg_pkg::IDX_RATE0 + 6'h1, -m);
    acc(0, 1, sdg_pkg::IDX_RATE0 + 6'h2, 32'h8000_0000);
    acc(1, 1, sdg_pkg::IDX_TARGET0, 5);
    acc(0, 1, sdg_pkg::IDX_TARGET0 + 6'h1, 3);
    acc(0, 1, sdg_pkg::IDX_COUNT0, m);
    tick(8);
    acc(1, 0, sdg_pkg::IDX_COUNT0, 0);
    cmp_pin(dir, 3'b110);
    acc(0, 1, sdg_pkg::IDX_CONFIG, 32'h311);
    tick(20);
    ce_i = 1'b0;
    tick(3);
    ce_i = 1'b1;
    tick(20);
    acc(1, 1, sdg_pkg::IDX_CONFIG, 0);
    tick(3);
    for (int c = 0; c < 3; c++) begin
      acc(c % 2, 0, sdg_pkg::IDX_TARGET0 + 6'(c), 0);
      acc(c % 2, 0, sdg_pkg::IDX_COUNT0 + 6'(c), pos[c]);
    end
    cmp_pin(pos[0], 5);
    cmp_pin(pos[1], -3);
    acc(0, 1, sdg_pkg::IDX_TARGET0, 32'h1000);
    acc(1, 1, sdg_pkg::IDX_CONFIG, 1);
    tick(5);
    acc(1, 1, sdg_pkg::IDX_TARGET0, 2);
    tick(12);
    acc(0, 0, sdg_pkg::IDX_TARGET0, 0);
    acc(1, 0, sdg_pkg::IDX_COUNT0, pos[0]);
    acc(0, 1, sdg_pkg::IDX_CONFIG, 32'hc);
    tick(2);
    cmp_pin({pulse[0], dir[0]}, 2'b11);
    final_report;
  end
endmodule : sdg_step_dir_gen_tb_top
bind sdg_step_dir_gen sdg_checker #(.NUM_CH(NUM_CH)) u_chk (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .ce_i(ce_i), .net_req_i(net_req_i), .net_rsp_o(net_rsp_o),
  .pdi_req_i(pdi_req_i), .pdi_rsp_o(pdi_rsp_o), .pulse_out_o(pulse_out_o),
  .pulse_out_inv_o(pulse_out_inv_o), .dir_out_o(dir_out_o), .dir_out_inv_o(dir_out_inv_o));
`default_nettype wire
